// file: rtl/sdf_pkg.sv
// Constants, types and helpers shared by the filter timing and calibration block.
// Assumes one 10 MHz reference clock; the modulator clock is a tick derived from it.
package sdf_pkg;
    // ****************************************
    // Timing and widths
    // ****************************************
    localparam int unsigned REF_HZ     = 32'h0098_9680;
    localparam int unsigned MCLK_HZ    = 32'h0001_2C00;
    localparam int unsigned MCLK_DIV   = REF_HZ / MCLK_HZ;
    localparam int unsigned DW         = 32'h0000_0010;
    localparam int unsigned AW         = 32'h0000_0008;
    localparam int unsigned SETUP_BITS = 32'h0000_0003;
    localparam int unsigned MEM_WORDS  = 32'h0000_0018;
    localparam int unsigned SETUPS     = 32'h0000_0008;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0]  A_CTRL    = 8'h00;
    localparam logic [7:0]  A_STATUS  = 8'h01;
    localparam logic [7:0]  A_DATA    = 8'h02;
    localparam logic [4:0]  PAGE_FILT = 5'h02;
    localparam logic [4:0]  PAGE_GAIN = 5'h04;
    localparam logic [1:0]  K_FILT    = 2'h0;
    localparam logic [1:0]  K_OFFS    = 2'h1;
    localparam logic [1:0]  K_GAIN    = 2'h2;
    localparam logic [15:0] FILT_RST  = 16'h1180;
    localparam logic [15:0] OFFS_RST  = 16'h8000;
    localparam logic [15:0] GAIN_RST  = 16'h5555;
    localparam int unsigned FM_LSB    = 32'h0000_000B;
    localparam int unsigned FM_MSB    = 32'h0000_000E;
    localparam int unsigned FS_MSB    = 32'h0000_000A;
    localparam int unsigned MODE_MSB  = 32'h0000_0003;
    localparam int unsigned CHAN_LSB  = 32'h0000_0004;
    localparam int unsigned CHAN_MSB  = 32'h0000_0006;

    // ****************************************
    // Filter and conversion constants
    // ****************************************
    localparam logic [10:0] FS_MIN       = 11'h001;
    localparam logic [10:0] SINC4_FS_MAX = 11'h00A;
    localparam logic [21:0] CNV_MUL      = 22'h00_0020;
    localparam logic [21:0] AVG4_MUL     = 22'h00_0160;
    localparam logic [21:0] AVG3_MUL     = 22'h00_0140;
    localparam logic [21:0] FIRST4_MUL   = 22'h00_0004;
    localparam logic [21:0] FIRST3_MUL   = 22'h00_0003;
    localparam logic [21:0] INT_GAIN_MUL = 22'h00_0004;
    localparam logic [21:0] POST1_LEN    = 22'h00_0B80;
    localparam logic [21:0] POST2_LEN    = 22'h00_0C80;
    localparam logic [21:0] POST3_LEN    = 22'h00_0F80;
    localparam logic [21:0] POST4_LEN    = 22'h00_1280;
    localparam logic [2:0]  SUB_LAST     = 3'h7;
    localparam int unsigned AVG_SHIFT    = 32'h0000_0003;

    typedef enum logic [3:0] {
        FLT_SINC4     = 4'h0,
        FLT_SINC4_AVG = 4'h1,
        FLT_SINC3     = 4'h2,
        FLT_SINC3_REJ = 4'h3,
        FLT_SINC3_AVG = 4'h4,
        FLT_POST1     = 4'h5,
        FLT_POST2     = 4'h6,
        FLT_POST3     = 4'h7,
        FLT_POST4     = 4'h8
    } filter_type;

    typedef enum logic [3:0] {
        MODE_CONT     = 4'h0,
        MODE_SINGLE   = 4'h1,
        MODE_IDLE     = 4'h4,
        MODE_INT_OFF  = 4'h5,
        MODE_INT_GAIN = 4'h6,
        MODE_SYS_OFF  = 4'h7,
        MODE_SYS_GAIN = 4'h8
    } ctrl_mode_type;

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic is_cal(input logic [3:0] m);
        return (m >= MODE_INT_OFF) && (m <= MODE_SYS_GAIN);
    endfunction

    function automatic logic is_avg(input logic [3:0] ft);
        return (ft == FLT_SINC4_AVG) || (ft == FLT_SINC3_AVG);
    endfunction

    function automatic logic [10:0] clamp_fs(input logic [3:0] ft, input logic [10:0] fs);
        logic [10:0] r;
        r = (fs < FS_MIN) ? FS_MIN : fs;
        if (((ft == FLT_SINC4) || (ft == FLT_SINC4_AVG)) && (r > SINC4_FS_MAX))
            r = SINC4_FS_MAX;
        return r;
    endfunction

    // Length of one conversion in modulator clock ticks
    function automatic logic [21:0] conv_len(input logic [3:0] ft, input logic [10:0] fs,
                                             input logic first);
        logic [21:0] f;
        logic [21:0] n;
        f = {11'h000, clamp_fs(ft, fs)};
        case (ft)
            FLT_SINC4_AVG: n = 22'(f * AVG4_MUL);
            FLT_SINC3_AVG: n = 22'(f * AVG3_MUL);
            FLT_POST1:     n = POST1_LEN;
            FLT_POST2:     n = POST2_LEN;
            FLT_POST3:     n = POST3_LEN;
            FLT_POST4:     n = POST4_LEN;
            default:       n = 22'(f * CNV_MUL);
        endcase
        if (first && (ft == FLT_SINC4))
            n = 22'(n * FIRST4_MUL);
        else if (first && ((ft == FLT_SINC3) || (ft == FLT_SINC3_REJ) || (ft > FLT_POST4)))
            n = 22'(n * FIRST3_MUL);
        return n;
    endfunction

    function automatic logic is_mem_addr(input logic [7:0] a);
        return (a[AW-1:SETUP_BITS] >= PAGE_FILT) && (a[AW-1:SETUP_BITS] <= PAGE_GAIN);
    endfunction

    function automatic logic [4:0] mem_index(input logic [7:0] a);
        return {2'(a[AW-1:SETUP_BITS] - PAGE_FILT), a[SETUP_BITS-1:0]};
    endfunction
endpackage

// file: rtl/cfg_if.sv
// Carrier between the control engine and the per-setup memory.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ns
`default_nettype none
interface cfg_if;
    logic        bus_we;
    logic [4:0]  bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic        eng_we;
    logic [4:0]  eng_addr;
    logic [15:0] eng_wdata;
    logic [15:0] eng_rdata;
    modport ctl (output bus_we, bus_addr, bus_wdata, eng_we, eng_addr, eng_wdata,
                 input bus_rdata, eng_rdata);
    modport mem (input bus_we, bus_addr, bus_wdata, eng_we, eng_addr, eng_wdata,
                 output bus_rdata, eng_rdata);
endinterface
`default_nettype wire

// file: rtl/setup_mem.sv
// Per-setup filter words and calibration coefficients, two registered read ports.
// Assumes the engine port never writes while the bus port writes the same word.
`timescale 1ns/1ns
`default_nettype none
module setup_mem
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    cfg_if.mem        port
);
    import sdf_pkg::*;

    typedef struct packed {
        logic [MEM_WORDS-1:0][15:0] word;
        logic [15:0]                bus_rd;
        logic [15:0]                eng_rd;
    } mem_state_type;

    mem_state_type q;
    mem_state_type d;

    always_comb
    begin
        d = q;
        d.bus_rd = (port.bus_addr < 5'(MEM_WORDS)) ? q.word[port.bus_addr] : '0;
        d.eng_rd = (port.eng_addr < 5'(MEM_WORDS)) ? q.word[port.eng_addr] : '0;
        if (port.bus_we && (port.bus_addr < 5'(MEM_WORDS)))
            d.word[port.bus_addr] = port.bus_wdata;
        // Coefficient update wins
        if (port.eng_we && (port.eng_addr < 5'(MEM_WORDS)))
            d.word[port.eng_addr] = port.eng_wdata;
        if (i_rst)
        begin
            d = '0;
            for (int k = 0; k < MEM_WORDS; k++)
            begin
                d.word[k] = (k < SETUPS) ? FILT_RST : (k < 2 * SETUPS) ? OFFS_RST : GAIN_RST;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        q <= d;
    end

    assign port.bus_rdata = q.bus_rd;
    assign port.eng_rdata = q.eng_rd;

    property p_rst_sinc3;
        @(posedge i_clk) i_rst |=> (q.word[SETUPS-1][FM_MSB:FM_LSB] == FLT_SINC3);
    endproperty
    a_rst_sinc3: assert property (p_rst_sinc3) else $error("setup not sinc3 after reset");
endmodule // setup_mem
`default_nettype wire

// file: rtl/conv_timer.sv
// Conversion timer: counts modulator ticks, pulses done after the set length.
// Assumes i_len is at least one tick.
`timescale 1ns/1ns
`default_nettype none
module conv_timer
#(
    parameter int unsigned DIV = sdf_pkg::MCLK_DIV
)
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic        i_abort,
    input  wire logic [21:0] i_len,
    output logic             o_done
);
    import sdf_pkg::*;

    typedef struct packed {
        logic        run;
        logic        done;
        logic [15:0] div;
        logic [21:0] cnt;
        logic [21:0] len;
    } tmr_state_type;

    tmr_state_type q;
    tmr_state_type d;
    logic [31:0]   el_q;

    always_comb
    begin
        d = q;
        d.done = 1'b0;
        if (q.run)
        begin
            if (q.div == 16'(DIV - 1))
            begin
                d.div = '0;
                if (q.cnt == q.len - 22'h00_0001)
                begin
                    d.run = 1'b0;
                    d.done = 1'b1;
                end
                else
                    d.cnt = q.cnt + 22'h00_0001;
            end
            else
                d.div = q.div + 16'h0001;
        end
        if (i_start)
        begin
            d.run = 1'b1;
            d.cnt = '0;
            d.div = '0;
            d.len = i_len;
        end
        if (i_abort || i_rst)
            d = '0;
    end

    always_ff @(posedge i_clk)
    begin
        q <= d;
        el_q <= i_start ? 32'h0000_0001 : el_q + 32'h0000_0001;
    end

    assign o_done = q.done;

    property p_done_time;
        @(posedge i_clk) disable iff (i_rst)
        q.done |-> (el_q == 32'(q.len) * DIV + 32'h0000_0001);
    endproperty
    a_done_time: assert property (p_done_time) else $error("conversion length wrong");
endmodule // conv_timer
`default_nettype wire

// file: rtl/sdf_top.sv
// Filter chain selection, conversion timing and calibration sequencing.
// Assumes the sinc core outside delivers its result on I_RAW_RESULT at each done.
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sdf_top
#(
    parameter int unsigned DIV = sdf_pkg::MCLK_DIV
)
(
    input  wire logic                   I_REF_CLK,
    input  wire logic                   I_RST,
    input  wire logic [sdf_pkg::AW-1:0] I_ADDR,
    input  wire logic [sdf_pkg::DW-1:0] I_WDATA,
    input  wire logic                   I_WR,
    input  wire logic                   I_RD,
    output logic      [sdf_pkg::DW-1:0] O_RDATA,
    input  wire logic [sdf_pkg::DW-1:0] I_RAW_RESULT,
    output logic      [sdf_pkg::DW-1:0] O_DATA,
    output logic                        O_DATA_READY,
    output logic      [2:0]             O_CHAN_SEL,
    output logic      [3:0]             O_FILTER_MODE,
    output logic      [10:0]            O_SPEED_WORD,
    output logic                        O_POS_TO_NEG_TIE,
    output logic                        O_INT_FULL_SCALE
);
    import sdf_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOAD = 2'b01,
        ST_ARM  = 2'b10,
        ST_RUN  = 2'b11
    } eng_state_type;

    typedef struct packed {
        eng_state_type st;
        logic [3:0]    mode;
        logic [2:0]    chan;
        logic [3:0]    ft;
        logic [10:0]   fs;
        logic          first;
        logic [2:0]    sub;
        logic [18:0]   acc;
        logic [21:0]   len;
        logic          pending;
        logic [15:0]   data;
        logic [15:0]   rdata;
        logic          rd_mem;
        logic          go;
    } top_state_type;

    top_state_type q;
    top_state_type d;
    logic          tmr_done;
    logic          abort;
    logic          cal_busy;
    logic          fin;
    logic [18:0]   acc_n;
    logic [15:0]   res;
    logic [21:0]   tot;
    logic [3:0]    new_mode;
    logic [3:0]    rd_ft;
    logic [31:0]   run_cyc_q;

    cfg_if cfg ();

    setup_mem u_mem
    (
        .i_clk (I_REF_CLK),
        .i_rst (I_RST),
        .port  (cfg.mem)
    );

    conv_timer #(.DIV(DIV)) u_timer
    (
        .i_clk   (I_REF_CLK),
        .i_rst   (I_RST),
        .i_start (q.go),
        .i_abort (abort),
        .i_len   (q.len),
        .o_done  (tmr_done)
    );

    // ****************************************
    // Register port and engine
    // ****************************************
    always_comb
    begin
        d = q;
        d.go = 1'b0;
        d.rdata = '0;
        d.rd_mem = 1'b0;
        abort = 1'b0;
        fin = 1'b0;
        tot = '0;
        res = '0;
        acc_n = q.acc + {3'h0, I_RAW_RESULT};
        new_mode = I_WDATA[MODE_MSB:0];
        rd_ft = cfg.eng_rdata[FM_MSB:FM_LSB];
        cal_busy = (q.st != ST_IDLE) && is_cal(q.mode);
        cfg.bus_addr = mem_index(I_ADDR);
        cfg.bus_wdata = I_WDATA;
        cfg.bus_we = 1'b0;
        cfg.eng_addr = {K_FILT, q.chan};
        cfg.eng_wdata = '0;
        cfg.eng_we = 1'b0;

        if (I_RD)
        begin
            case (I_ADDR)
                A_CTRL:   d.rdata = {9'h000, q.chan, q.mode};
                A_STATUS: d.rdata = {9'h000, q.ft, q.st, q.pending};
                A_DATA:   d.rdata = q.data;
                default:  d.rd_mem = is_mem_addr(I_ADDR);
            endcase
        end

        // Coefficients and filter words are frozen during a calibration
        if (I_WR && is_mem_addr(I_ADDR) && !cal_busy)
            cfg.bus_we = 1'b1;

        case (q.st)
            ST_LOAD:
            begin
                d.st = ST_ARM;
            end
            ST_ARM:
            begin
                d.ft = rd_ft;
                d.fs = clamp_fs(rd_ft, cfg.eng_rdata[FS_MSB:0]);
                tot = conv_len(rd_ft, cfg.eng_rdata[FS_MSB:0], q.first || is_cal(q.mode));
                if (q.mode == MODE_INT_GAIN)
                    tot = 22'(tot * INT_GAIN_MUL);
                d.len = is_avg(rd_ft) ? (tot >> AVG_SHIFT) : tot;
                d.sub = '0;
                d.acc = '0;
                d.go = 1'b1;
                d.pending = 1'b1;
                d.st = ST_RUN;
            end
            ST_RUN:
            begin
                if (tmr_done && is_avg(q.ft) && (q.sub != SUB_LAST))
                begin
                    d.acc = acc_n;
                    d.sub = q.sub + 3'h1;
                    d.go = 1'b1;
                end
                else if (tmr_done)
                begin
                    fin = 1'b1;
                    res = is_avg(q.ft) ? 16'(acc_n >> AVG_SHIFT) : acc_n[DW-1:0];
                    d.pending = 1'b0;
                    d.first = 1'b0;
                    if (is_cal(q.mode))
                    begin
                        cfg.eng_we = 1'b1;
                        cfg.eng_addr = {((q.mode == MODE_INT_GAIN) || (q.mode == MODE_SYS_GAIN))
                                        ? K_GAIN : K_OFFS, q.chan};
                        cfg.eng_wdata = res;
                        d.mode = MODE_IDLE;
                        d.st = ST_IDLE;
                    end
                    else
                    begin
                        d.data = res;
                        d.st = (q.mode == MODE_SINGLE) ? ST_IDLE : ST_LOAD;
                        if (q.mode == MODE_SINGLE)
                            d.mode = MODE_IDLE;
                    end
                end
            end
            default:
            begin
                d.st = ST_IDLE;
            end
        endcase

        // Control write restarts or stops; ignored while calibrating
        if (I_WR && (I_ADDR == A_CTRL) && !cal_busy)
        begin
            abort = 1'b1;
            d.go = 1'b0;
            d.mode = new_mode;
            d.chan = I_WDATA[CHAN_MSB:CHAN_LSB];
            d.first = 1'b1;
            if ((new_mode == MODE_CONT) || (new_mode == MODE_SINGLE) || is_cal(new_mode))
            begin
                d.st = ST_LOAD;
                d.pending = is_cal(new_mode);
            end
            else
            begin
                d.st = ST_IDLE;
                d.pending = 1'b0;
            end
        end

        if (I_RST)
        begin
            d = '0;
            d.mode = MODE_IDLE;
            d.ft = FLT_SINC3;
        end
    end

    always_ff @(posedge I_REF_CLK)
    begin
        q <= d;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign O_RDATA          = q.rd_mem ? cfg.bus_rdata : q.rdata;
    assign O_DATA           = q.data;
    assign O_DATA_READY     = q.pending;
    assign O_CHAN_SEL       = q.chan;
    assign O_FILTER_MODE    = q.ft;
    assign O_SPEED_WORD     = q.fs;
    assign O_POS_TO_NEG_TIE = (q.st != ST_IDLE) && (q.mode == MODE_INT_OFF);
    assign O_INT_FULL_SCALE = (q.st != ST_IDLE) && (q.mode == MODE_INT_GAIN);

    // ****************************************
    // Checks
    // ****************************************
    always_ff @(posedge I_REF_CLK)
    begin
        run_cyc_q <= (I_RST || (q.st == ST_ARM)) ? 32'h0000_0000 : run_cyc_q + 32'h0000_0001;
    end

    property p_tie;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (q.st == ST_RUN) |-> (O_POS_TO_NEG_TIE == (q.mode == MODE_INT_OFF))
                             && !(O_POS_TO_NEG_TIE && O_INT_FULL_SCALE);
    endproperty
    a_tie: assert property (p_tie) else $error("input tie wrong during run");

    property p_cal_start;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_WR && (I_ADDR == A_CTRL) && !cal_busy && is_cal(I_WDATA[MODE_MSB:0]))
        |=> O_DATA_READY [*3];
    endproperty
    a_cal_start: assert property (p_cal_start) else $error("pending not raised at cal start");

    property p_cal_end;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (fin && is_cal(q.mode)) |-> cfg.eng_we ##1 ((q.st == ST_IDLE) && !O_DATA_READY && (q.mode == MODE_IDLE));
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("cal completion sequence wrong");

    property p_cal_time;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (fin && is_cal(q.mode) && (q.mode != MODE_INT_GAIN))
        |-> run_cyc_q <= 32'(conv_len(q.ft, q.fs, 1'b1)) * DIV + 32'h0000_0010;
    endproperty
    a_cal_time: assert property (p_cal_time) else $error("calibration too long");

    property p_sinc4_clamp;
        @(posedge I_REF_CLK) disable iff (I_RST)
        ((q.st == ST_RUN) && ((q.ft == FLT_SINC4) || (q.ft == FLT_SINC4_AVG)))
        |-> (q.fs <= SINC4_FS_MAX) && (q.fs >= FS_MIN);
    endproperty
    a_sinc4_clamp: assert property (p_sinc4_clamp) else $error("sinc4 speed not clamped");

    property p_post_fixed;
        @(posedge I_REF_CLK) disable iff (I_RST)
        ((q.st == ST_RUN) && (q.ft == FLT_POST4)) |-> (q.len == POST4_LEN);
    endproperty
    a_post_fixed: assert property (p_post_fixed) else $error("post filter length moved");

    property p_avg_flat;
        @(posedge I_REF_CLK) disable iff (I_RST)
        ((q.st == ST_RUN) && is_avg(q.ft) && !is_cal(q.mode))
        |-> (q.len == (conv_len(q.ft, q.fs, 1'b0) >> AVG_SHIFT));
    endproperty
    a_avg_flat: assert property (p_avg_flat) else $error("averaging first conversion differs");

    property p_avg_eight;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (fin && is_avg(q.ft)) |-> (q.sub == SUB_LAST);
    endproperty
    a_avg_eight: assert property (p_avg_eight) else $error("average not over eight outputs");

    property p_settled;
        @(posedge I_REF_CLK) disable iff (I_RST)
        ((q.st == ST_RUN) && !q.first && ((q.ft == FLT_SINC3) || (q.ft == FLT_SINC4)))
        |-> (q.len == 22'({11'h000, q.fs} * CNV_MUL));
    endproperty
    a_settled: assert property (p_settled) else $error("settled length not 32 times speed");

    c_cal_done: cover property (@(posedge I_REF_CLK) disable iff (I_RST) fin && is_cal(q.mode));
    c_avg_done: cover property (@(posedge I_REF_CLK) disable iff (I_RST) fin && is_avg(q.ft));
    c_post_done: cover property (@(posedge I_REF_CLK) disable iff (I_RST)
                                 fin && (q.ft >= FLT_POST1) && (q.ft <= FLT_POST4));
endmodule // sdf_top
`default_nettype wire

// file: dv/sinc_core_model.sv
// Stand-in for the sinc core beside the block.
// Assumes a shorted input reads a small residue and full scale a fixed code.
`timescale 1ns/1ns
`default_nettype none
module sinc_core_model
(
    input  wire logic        i_tie,
    input  wire logic        i_fs,
    input  wire logic [15:0] i_level,
    output logic      [15:0] o_raw
);
    assign o_raw = i_tie ? 16'h0040 : (i_fs ? 16'h5A5A : i_level);
endmodule // sinc_core_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for sdf_top.
// Assumes DIV of 1, so one modulator tick per clock.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import sdf_pkg::*;
    logic        I_REF_CLK = 1'b0;
    logic        I_RST = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wd = 16'h0000;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [15:0] lvl = 16'h0000;
    logic [15:0] rdata, raw, dout;
    logic        rdy, tie, fsc, p1, t_any, g_any;
    logic [3:0]  fmode;
    logic [10:0] spd;
    logic [2:0]  chan;
    int          fail_count = 0;
    int          checks_done = 0;
    int          n;
    always #50 I_REF_CLK = ~I_REF_CLK;
    sdf_top #(.DIV(1)) u_dut (.I_REF_CLK(I_REF_CLK), .I_RST(I_RST), .I_ADDR(addr),
        .I_WDATA(wd), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_RAW_RESULT(raw),
        .O_DATA(dout), .O_DATA_READY(rdy), .O_CHAN_SEL(chan), .O_FILTER_MODE(fmode),
        .O_SPEED_WORD(spd), .O_POS_TO_NEG_TIE(tie), .O_INT_FULL_SCALE(fsc));
    sinc_core_model u_core (.i_tie(tie), .i_fs(fsc), .i_level(lvl), .o_raw(raw));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge I_REF_CLK);
        addr <= a;
        wd <= d;
        wr_s <= 1'b1;
        @(posedge I_REF_CLK);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge I_REF_CLK);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge I_REF_CLK);
        rd_s <= 1'b0;
        #1 d = rdata;
    endtask
    // Starts a mode and counts cycles until pending falls
    task automatic run(input logic [15:0] c);
        wr(A_CTRL, c);
        n = 1;
        #1 p1 = rdy;
        t_any = 1'b0;
        g_any = 1'b0;
        while (n < 20000 && !(n > 3 && rdy === 1'b0))
        begin
            t_any |= tie;
            g_any |= fsc;
            @(posedge I_REF_CLK);
            #1 n++;
        end
        if (n >= 20000)
        begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic test_reset();
        logic [15:0] d;
        for (int i = 0; i < 8; i++)
        begin
            rd(8'h10 + 8'(i), d);
            chk("filter reset", d, 16'h1180);
        end
        chk("chain reset", fmode, 4'h2);
        rd(8'h30, d);
        chk("unmapped", d, 16'h0000);
        $display("test_reset done");
    endtask
    task automatic test_filters();
        // Pending-fall cycle of each chain with speed word 12 (the sinc4 chains clamp it to 10)
        int en[9] = '{1285, 3539, 1157, 1157, 3859, 2949, 3205, 3973, 4741};
        lvl <= 16'h1234;
        for (int c = 0; c < 9; c++)
        begin
            wr(8'h10, 16'((c << 11) | 12));
            run(16'h0001);
            chk("conv cycles", n, en[c]);
            chk("chain", fmode, c);
            chk("data", dout, 16'h1234);
            if (c < 5)
                chk("speed", spd, (c < 2) ? 10 : 12);
        end
        $display("test_filters done");
    endtask
    task automatic test_cal();
        logic [15:0] d;
        logic [3:0]  m[4] = '{4'h6, 4'h5, 4'h7, 4'h8};
        logic [15:0] e[4] = '{16'h5A5A, 16'h0040, 16'h0100, 16'h6000};
        for (int i = 0; i < 4; i++)
        begin
            lvl <= e[i];
            wr(8'h10 + 8'(i), 16'h1002);
            run({9'h000, 3'(i), m[i]});
            chk("cal cycles", n, (i == 0) ? 773 : 197);
            chk("pending at start", p1, 1'b1);
            chk("tie", t_any, i == 1);
            chk("full scale", g_any, i == 0);
            chk("channel", chan, i);
            rd((i == 1 || i == 2) ? 8'h18 + 8'(i) : 8'h20 + 8'(i), d);
            chk("coefficient", d, e[i]);
            rd(8'h00, d);
            chk("idle", d[3:0], 4'h4);
        end
        $display("test_cal done");
    endtask
    // Continuous sinc3: first conversion, then one settled conversion
    task automatic test_cont();
        wr(8'h10, 16'h100C);
        run(16'h0000);
        chk("first cycles", n, 1157);
        n = 0;
        while (n < 2000 && rdy !== 1'b1)
        begin
            @(posedge I_REF_CLK);
            #1 n++;
        end
        while (n < 2000 && rdy !== 1'b0)
        begin
            @(posedge I_REF_CLK);
            #1 n++;
        end
        if (n >= 2000)
        begin
            fail_count++;
            final_report();
        end
        chk("settled cycles", n, 388);
        wr(A_CTRL, 16'h0004);
        #1 chk("stopped", rdy, 1'b0);
        $display("test_cont done");
    endtask
    initial
    begin
        repeat (8) @(posedge I_REF_CLK);
        I_RST <= 1'b0;
        test_reset();
        test_filters();
        test_cal();
        test_cont();
        final_report();
    end
endmodule // testbench
`default_nettype wire
